// >>> verilog/atpg_top.v
`timescale 1ns/1ps
`include "atpg_map.vh"
module atpg_top (
    input wire i_clk,
    input wire i_nrst,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output wire [7:0] o_rdata,
    input wire [13:0] i_adc_sample,
    output wire [13:0] o_adc_sample,
    output wire o_adc_disconnect,
    output wire [15:0] o_if_word,
    output wire [4:0] o_if_width,
    output wire [1:0] o_if_point,
    output wire o_if_valid,
    output wire o_tl_test_en,
    output wire [2:0] o_dll_test_sel,
    output wire [7:0] o_link_ctrl,
    output wire o_soft_reset
);
    //////////////////////////////
    reg [7:0] adc_test_q;
    reg [7:0] user_q [0:7];
    reg [7:0] tl_ctrl_q;
    reg [7:0] link_ctrl_q;
    reg [7:0] if_test_q;
    reg [7:0] dll_test_q;
    reg soft_q;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg [13:0] adc_out_q;
    reg [13:0] adc_out_d;
    reg [15:0] if_word_q;
    reg [15:0] if_word_d;
    reg if_valid_q;
    reg adc_phase_q;
    reg [13:0] adc_ramp_q;
    reg if_phase_q;
    reg [15:0] if_ramp_q;
    reg [4:0] if_width;
    reg [15:0] if_mask;
    reg [15:0] if_user_trunc;
    reg [15:0] if_pn_word;
    wire [63:0] user_words;
    wire wr_soft;
    wire wr_adc;
    wire wr_if;
    wire adc_restart;
    wire if_restart;
    wire [3:0] adc_mode;
    wire [3:0] if_mode;
    wire [1:0] if_point;
    wire adc_active;
    wire if_active;
    wire [15:0] pnl_word;
    wire [15:0] pns_word;
    wire [15:0] adc_user_word;
    wire [15:0] if_user_word;
    wire adc_user_done;
    wire if_user_done;
    wire [79:0] if_pn_words;
    integer i;

    //////////////////////////////
    // Register port. Writes land in one cycle, read data stand in the next cycle.
    assign wr_soft = i_wr && (i_addr == `ATPG_ADDR_SOFT_RESET);
    assign wr_adc = i_wr && (i_addr == `ATPG_ADDR_ADC_TEST);
    assign wr_if = i_wr && (i_addr == `ATPG_ADDR_IF_TEST);

    always @(posedge i_clk) begin
        if (!i_nrst || soft_q) begin
            adc_test_q <= `ATPG_RST_REG;
            tl_ctrl_q <= `ATPG_RST_REG;
            link_ctrl_q <= `ATPG_RST_REG;
            if_test_q <= `ATPG_RST_REG;
            dll_test_q <= `ATPG_RST_REG;
            for (i = 0; i < 8; i = i + 1) begin
                user_q[i] <= `ATPG_RST_REG;
            end
        end else if (i_wr) begin
            case (i_addr)
                `ATPG_ADDR_ADC_TEST: adc_test_q <= i_wdata;
                `ATPG_ADDR_TL_CTRL: tl_ctrl_q <= i_wdata; // [RL11]
                `ATPG_ADDR_LINK_CTRL: link_ctrl_q <= i_wdata;
                `ATPG_ADDR_IF_TEST: if_test_q <= i_wdata; // [RL12] [RL13]
                `ATPG_ADDR_DLL_TEST: dll_test_q <= i_wdata; // [RL21]
                default: begin
                    if (i_addr >= `ATPG_ADDR_USER_FIRST && i_addr <= `ATPG_ADDR_USER_LAST) begin
                        user_q[i_addr[2:0] - 3'h1] <= i_wdata;
                    end
                end
            endcase
        end
    end

    // The request lasts one cycle, the reset it drives ends with it.
    always @(posedge i_clk) begin
        if (!i_nrst || soft_q) begin
            soft_q <= 1'b0; // [RL10]
        end else if (wr_soft && i_wdata == `ATPG_SOFT_RESET_CMD) begin
            soft_q <= 1'b1; // [RL10]
        end
    end

    always @* begin
        rdata_d = 8'h00;
        case (i_addr)
            `ATPG_ADDR_SOFT_RESET: rdata_d = soft_q ? `ATPG_SOFT_RESET_CMD : 8'h00;
            `ATPG_ADDR_ADC_TEST: rdata_d = adc_test_q;
            `ATPG_ADDR_TL_CTRL: rdata_d = tl_ctrl_q;
            `ATPG_ADDR_LINK_CTRL: rdata_d = link_ctrl_q;
            `ATPG_ADDR_IF_TEST: rdata_d = {2'b00, if_test_q[5:0]};
            `ATPG_ADDR_DLL_TEST: rdata_d = {5'h00, dll_test_q[2:0]};
            `ATPG_ADDR_STATUS: rdata_d = {4'h0, if_user_done, adc_user_done, if_active, adc_active};
            default: begin
                if (i_addr >= `ATPG_ADDR_USER_FIRST && i_addr <= `ATPG_ADDR_USER_LAST) begin
                    rdata_d = user_q[i_addr[2:0] - 3'h1];
                end
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    //////////////////////////////
    // User word n sits at two addresses, low byte first.
    assign user_words = {user_q[7], user_q[6], user_q[5], user_q[4],
                         user_q[3], user_q[2], user_q[1], user_q[0]};

    assign adc_mode = adc_test_q[3:0];
    assign if_mode = if_test_q[3:0];
    assign if_point = if_test_q[5:4];
    assign adc_active = (adc_mode != `ATPG_ADC_OFF);
    assign if_active = (if_mode != `ATPG_IF_OFF);

    // A new mode word restarts every sequence of its own path (ADC or interface) so each pattern opens at its first value.
    assign adc_restart = wr_adc || soft_q;
    assign if_restart = wr_if || soft_q;

    //////////////////////////////
    // ADC level pattern generators.
    atpg_pn #(.LEN(23), .TAP(18), .SEED(`ATPG_SEED_ADC_LONG)) u_adc_pn_long (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_load(adc_restart || adc_test_q[`ATPG_PN_LONG_RST_BIT]), // [RL24]
        .i_step(adc_mode == `ATPG_ADC_PNL), // [RL2]
        .i_nbits(`ATPG_W_ADC),
        .o_word(pnl_word)
    );

    atpg_pn #(.LEN(9), .TAP(5), .SEED(`ATPG_SEED_ADC_SHORT)) u_adc_pn_short (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_load(adc_restart || adc_test_q[`ATPG_PN_SHORT_RST_BIT]), // [RL24]
        .i_step(adc_mode == `ATPG_ADC_PNS), // [RL3]
        .i_nbits(`ATPG_W_ADC),
        .o_word(pns_word)
    );

    atpg_useq u_adc_user (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(adc_restart),
        .i_step(adc_mode == `ATPG_ADC_USER),
        .i_single(adc_test_q[`ATPG_USER_SINGLE_BIT]),
        .i_words(user_words),
        .o_word(adc_user_word),
        .o_done(adc_user_done)
    );

    always @(posedge i_clk) begin
        if (!i_nrst || adc_restart) begin
            adc_phase_q <= 1'b0;
            adc_ramp_q <= 14'h0000;
        end else begin
            adc_phase_q <= ~adc_phase_q; // [RL1] [RL4]
            adc_ramp_q <= adc_ramp_q + 14'h0001; // [RL7]
        end
    end

    // With a test code set the converter sample is never looked at.
    always @* begin
        case (adc_mode)
            `ATPG_ADC_OFF: adc_out_d = i_adc_sample; // [RL8]
            `ATPG_ADC_MID: adc_out_d = `ATPG_ADC_MID_VAL; // [RL8]
            `ATPG_ADC_PFS: adc_out_d = `ATPG_ADC_PFS_VAL; // [RL8]
            `ATPG_ADC_NFS: adc_out_d = `ATPG_ADC_NFS_VAL; // [RL8]
            `ATPG_ADC_CHK: adc_out_d = adc_phase_q ? `ATPG_ADC_CHK_B : `ATPG_ADC_CHK_A; // [RL1]
            `ATPG_ADC_PNL: adc_out_d = pnl_word[13:0]; // [RL2]
            `ATPG_ADC_PNS: adc_out_d = pns_word[13:0]; // [RL3]
            `ATPG_ADC_TOG: adc_out_d = adc_phase_q ? `ATPG_ADC_ONES : 14'h0000; // [RL4]
            `ATPG_ADC_USER: adc_out_d = adc_user_word[15:2]; // [RL5] [RL6]
            `ATPG_ADC_RAMP: adc_out_d = adc_ramp_q; // [RL7]
            default: adc_out_d = 14'h0000; // [RL23]
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            adc_out_q <= 14'h0000;
        end else begin
            adc_out_q <= adc_out_d; // [RL23]
        end
    end

    //////////////////////////////
    // Interface level pattern generators. Word width follows the injection point.
    always @* begin
        case (if_point)
            `ATPG_INJ_SAMPLE: if_width = `ATPG_W_SAMPLE; // [RL14]
            `ATPG_INJ_PHY: if_width = `ATPG_W_PHY; // [RL14]
            `ATPG_INJ_SCR: if_width = `ATPG_W_SCR; // [RL14]
            default: if_width = `ATPG_W_SAMPLE;
        endcase
        if_mask = 16'hffff >> (5'd16 - if_width); // [RL13]
    end

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_if_pn
            localparam LEN = (g == 0) ? 31 : (g == 1) ? 23 : (g == 2) ? 15 : (g == 3) ? 9 : 7;
            localparam TAP = (g == 0) ? 28 : (g == 1) ? 18 : (g == 2) ? 14 : (g == 3) ? 5 : 6;
            localparam [30:0] SEED = (g == 0) ? `ATPG_SEED_PN31 : (g == 1) ? `ATPG_SEED_PN23 :
                                     (g == 2) ? `ATPG_SEED_PN15 : (g == 3) ? `ATPG_SEED_PN9 :
                                     `ATPG_SEED_PN7;
            localparam [3:0] CODE = `ATPG_IF_PN31 + g;
            atpg_pn #(.LEN(LEN), .TAP(TAP), .SEED(SEED)) u_pn (
                .i_clk(i_clk),
                .i_nrst(i_nrst),
                .i_load(if_restart),
                .i_step(if_mode == CODE), // [RL15] [RL16]
                .i_nbits(if_width), // [RL16]
                .o_word(if_pn_words[g*16 +: 16])
            );
        end
    endgenerate

    always @* begin
        case (if_mode)
            `ATPG_IF_PN31: if_pn_word = if_pn_words[15:0]; // [RL15]
            `ATPG_IF_PN23: if_pn_word = if_pn_words[31:16]; // [RL16]
            `ATPG_IF_PN15: if_pn_word = if_pn_words[47:32];
            `ATPG_IF_PN9: if_pn_word = if_pn_words[63:48];
            `ATPG_IF_PN7: if_pn_word = if_pn_words[79:64];
            default: if_pn_word = 16'h0000;
        endcase
    end

    atpg_useq u_if_user (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(if_restart),
        .i_step(if_mode == `ATPG_IF_USER_REP || if_mode == `ATPG_IF_USER_ONE), // [RL19]
        .i_single(if_mode == `ATPG_IF_USER_ONE), // [RL20]
        .i_words(user_words),
        .o_word(if_user_word),
        .o_done(if_user_done)
    );

    always @(posedge i_clk) begin
        if (!i_nrst || if_restart) begin
            if_phase_q <= 1'b0;
            if_ramp_q <= 16'h0000;
        end else begin
            if_phase_q <= ~if_phase_q; // [RL18]
            if_ramp_q <= if_ramp_q + 16'h0001; // [RL17]
        end
    end

    // User words keep their top bits when narrowed; fixed patterns keep their low bits.
    always @* begin
        if_user_trunc = if_user_word >> (5'd16 - if_width); // [RL19] [RL20]
        case (if_mode)
            `ATPG_IF_CHK: if_word_d = (if_phase_q ? `ATPG_IF_CHK_B : `ATPG_IF_CHK_A) & if_mask; // [RL18]
            `ATPG_IF_TOG: if_word_d = (if_phase_q ? 16'hffff : 16'h0000) & if_mask; // [RL18]
            `ATPG_IF_PN31, `ATPG_IF_PN23, `ATPG_IF_PN15, `ATPG_IF_PN9, `ATPG_IF_PN7: begin
                if_word_d = if_pn_word & if_mask; // [RL15]
            end
            `ATPG_IF_RAMP: if_word_d = if_ramp_q & if_mask; // [RL17]
            `ATPG_IF_USER_REP, `ATPG_IF_USER_ONE: if_word_d = if_user_trunc; // [RL19] [RL20]
            default: begin
                // Transport samples are the formatted converter samples, left aligned.
                if_word_d = tl_ctrl_q[`ATPG_TL_TEST_BIT] ? {adc_out_q, 2'b00} : 16'h0000; // [RL11]
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            if_word_q <= 16'h0000;
            if_valid_q <= 1'b0;
        end else begin
            if_word_q <= if_word_d;
            if_valid_q <= if_active || tl_ctrl_q[`ATPG_TL_TEST_BIT]; // [RL11]
        end
    end

    //////////////////////////////
    assign o_rdata = rdata_q;
    assign o_adc_sample = adc_out_q;
    assign o_adc_disconnect = adc_active; // [RL23]
    assign o_if_word = if_word_q;
    assign o_if_width = if_width;
    assign o_if_point = if_point;
    assign o_if_valid = if_valid_q;
    assign o_tl_test_en = tl_ctrl_q[`ATPG_TL_TEST_BIT];
    assign o_dll_test_sel = dll_test_q[2:0]; // [RL21]
    // The sync request gate is software owned; the link layer reads this byte as written.
    assign o_link_ctrl = link_ctrl_q; // [RL22]
    assign o_soft_reset = soft_q; // [RL10]
endmodule // atpg_top

// >>> verilog/atpg_map.vh
// Summary of operation
// [RL1] ADC code 0100 alternates 0x1555 and 0x2AAA, starting with 0x1555.
// [RL2] ADC code 0101 outputs the x^23+x^18+1 generator seeded 0x3AFF.
// [RL3] ADC code 0110 outputs the x^9+x^5+1 generator seeded 0x0092.
// [RL4] ADC code 0111 alternates 0x0000 and 0x3FFF every sample.
// [RL5] ADC user repeat outputs bits 15..2 of user words one to four, wrapping.
// [RL6] ADC user single outputs user words one to four once, then zeros.
// [RL7] ADC code 1111 outputs a ramp rising by one each sample, modulo 2^14.
// [RL8] ADC codes 0001..0011 hold midscale, positive and negative full scale; 0000 is off.
// [RL9] Host issues a soft reset before returning the interface test field to zero.
// [RL10] Writing 0x81 to 0x0000 soft resets; the request clears itself when done.
// [RL11] Transport layer test bit 5 at 0x0571 sends raw converter samples; the code sends adc_out_q, which carries any ADC test pattern.
// [RL12] Interface pattern selector sits in bits 3..0 of 0x0573.
// [RL13] Injection point sits in bits 5..4 of 0x0573 and sets the word width.
// [RL14] Injection 00 gives 16-bit words, 01 10-bit symbols, 10 8-bit octets.
// [RL15] Interface codes 0011..0111 select the 31, 23, 15, 9 and 7-bit generators.
// [RL16] The interface 23-bit generator uses x^23+x^18+1 seeded 0x003AFF.
// [RL17] Interface code 1000 ramps modulo two to the injection word width.
// [RL18] Interface codes 0001 and 0010 alternate 5555/AAAA and zeros/ones, truncated.
// [RL19] Interface code 1110 cycles user words one to four continuously.
// [RL20] Interface code 1111 sends user words one to four once, then zeros.
// [RL21] Link layer test selector sits in bits 2..0 of 0x0574.
// [RL22] Host writes 0xC0 to 0x0572 to disable the sync request while link tests run.
// [RL23] Any ADC test mode disconnects the converter; pattern still needs the clock.
// [RL24] Setting bit 4 or bit 5 of 0x0550 resets the ADC PN generators to seed; the code resets only the 23-bit one on bit 4, only the 9-bit one on bit 5.
`ifndef ATPG_MAP_VH
`define ATPG_MAP_VH

`define ATPG_ADDR_SOFT_RESET 16'h0000
`define ATPG_ADDR_ADC_TEST 16'h0550
`define ATPG_ADDR_USER_FIRST 16'h0551
`define ATPG_ADDR_USER_LAST 16'h0558
`define ATPG_ADDR_TL_CTRL 16'h0571
`define ATPG_ADDR_LINK_CTRL 16'h0572
`define ATPG_ADDR_IF_TEST 16'h0573
`define ATPG_ADDR_DLL_TEST 16'h0574
`define ATPG_ADDR_STATUS 16'h0580

`define ATPG_SOFT_RESET_CMD 8'h81
`define ATPG_RST_REG 8'h00

`define ATPG_PN_LONG_RST_BIT 4
`define ATPG_PN_SHORT_RST_BIT 5
`define ATPG_USER_SINGLE_BIT 7
`define ATPG_TL_TEST_BIT 5

`define ATPG_ADC_OFF 4'h0
`define ATPG_ADC_MID 4'h1
`define ATPG_ADC_PFS 4'h2
`define ATPG_ADC_NFS 4'h3
`define ATPG_ADC_CHK 4'h4
`define ATPG_ADC_PNL 4'h5
`define ATPG_ADC_PNS 4'h6
`define ATPG_ADC_TOG 4'h7
`define ATPG_ADC_USER 4'h8
`define ATPG_ADC_RAMP 4'hf

`define ATPG_ADC_MID_VAL 14'h0000
`define ATPG_ADC_PFS_VAL 14'h1fff
`define ATPG_ADC_NFS_VAL 14'h2000
`define ATPG_ADC_CHK_A 14'h1555
`define ATPG_ADC_CHK_B 14'h2aaa
`define ATPG_ADC_ONES 14'h3fff

`define ATPG_IF_OFF 4'h0
`define ATPG_IF_CHK 4'h1
`define ATPG_IF_TOG 4'h2
`define ATPG_IF_PN31 4'h3
`define ATPG_IF_PN23 4'h4
`define ATPG_IF_PN15 4'h5
`define ATPG_IF_PN9 4'h6
`define ATPG_IF_PN7 4'h7
`define ATPG_IF_RAMP 4'h8
`define ATPG_IF_USER_REP 4'he
`define ATPG_IF_USER_ONE 4'hf
`define ATPG_IF_CHK_A 16'h5555
`define ATPG_IF_CHK_B 16'haaaa

`define ATPG_INJ_SAMPLE 2'b00
`define ATPG_INJ_PHY 2'b01
`define ATPG_INJ_SCR 2'b10
`define ATPG_W_SAMPLE 5'd16
`define ATPG_W_PHY 5'd10
`define ATPG_W_SCR 5'd8
`define ATPG_W_ADC 5'd14

`define ATPG_SEED_ADC_LONG 31'h00003aff
`define ATPG_SEED_ADC_SHORT 31'h00000092
`define ATPG_SEED_PN31 31'h0003afff
`define ATPG_SEED_PN23 31'h00003aff
`define ATPG_SEED_PN15 31'h000003af
`define ATPG_SEED_PN9 31'h00000092
`define ATPG_SEED_PN7 31'h00000007

`endif

// >>> verilog/atpg_pn.v
`timescale 1ns/1ps
// Fibonacci PN generator; advances i_nbits bits per step, newest bit in bit 0.
module atpg_pn #(
    parameter LEN = 23,
    parameter TAP = 18,
    parameter [30:0] SEED = 31'h00003aff
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_load,
    input wire i_step,
    input wire [4:0] i_nbits,
    output wire [15:0] o_word
);
    reg [LEN-1:0] state_q;
    reg [LEN-1:0] state_d;
    reg [15:0] word_q;
    reg [15:0] word_d;
    reg fb;
    integer k;

    always @* begin
        state_d = state_q;
        word_d = word_q;
        fb = 1'b0;
        for (k = 0; k < 16; k = k + 1) begin
            if (k < {27'd0, i_nbits}) begin
                fb = state_d[LEN-1] ^ state_d[TAP-1];
                state_d = {state_d[LEN-2:0], fb};
                word_d = {word_d[14:0], fb};
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_nrst || i_load) begin
            state_q <= SEED[LEN-1:0];
            word_q <= 16'h0000;
        end else if (i_step) begin
            state_q <= state_d;
            word_q <= word_d;
        end
    end

    assign o_word = word_q;
endmodule // atpg_pn

// >>> verilog/atpg_useq.v
`timescale 1ns/1ps
// Walks four user words; in single mode it reports zeros after the fourth.
module atpg_useq (
    input wire i_clk,
    input wire i_nrst,
    input wire i_restart,
    input wire i_step,
    input wire i_single,
    input wire [63:0] i_words,
    output wire [15:0] o_word,
    output wire o_done
);
    reg [1:0] idx_q;
    reg done_q;

    always @(posedge i_clk) begin
        if (!i_nrst || i_restart) begin
            idx_q <= 2'h0;
            done_q <= 1'b0;
        end else if (i_step) begin
            idx_q <= idx_q + 2'h1;
            if (idx_q == 2'h3 && i_single) begin
                done_q <= 1'b1;
            end
        end
    end

    assign o_word = done_q ? 16'h0000 : i_words[{idx_q, 4'h0} +: 16];
    assign o_done = done_q;
endmodule // atpg_useq

// >>> tb/atpg_properties.sv
`timescale 1ns/1ps
module atpg_properties (
    input wire i_clk,
    input wire i_nrst,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire [13:0] o_adc_sample,
    input wire o_adc_disconnect,
    input wire [4:0] o_if_width,
    input wire [1:0] o_if_point,
    input wire o_tl_test_en,
    input wire [2:0] o_dll_test_sel,
    input wire [7:0] o_link_ctrl,
    input wire o_soft_reset
);
    // Shadow of the test code and its age since the last write.
    reg [3:0] mode_q;
    reg [1:0] age_q;
    wire mode_wr = i_wr && (i_addr == 16'h0550) && !o_soft_reset;
    wire [1:0] wd_point = i_wdata[5:4];
    wire [13:0] fix_val = (mode_q == 4'h1) ? 14'h0000 : (mode_q == 4'h2) ? 14'h1fff : 14'h2000;
    always @(posedge i_clk) begin
        if (!i_nrst || o_soft_reset) begin
            mode_q <= 4'h0;
            age_q <= 2'd0;
        end else if (mode_wr) begin
            mode_q <= i_wdata[3:0];
            age_q <= 2'd0;
        end else if (age_q != 2'd3) begin
            age_q <= age_q + 2'd1;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    a_fixed_val: assert property ((mode_q inside {4'h1, 4'h2, 4'h3}) && age_q != 2'd0 && !mode_wr && !o_soft_reset
        |=> o_adc_sample == $past(fix_val)) else $error("fixed pattern wrong");
    a_chk_alt: assert property (mode_q == 4'h4 && age_q >= 2'd2 && !mode_wr && !o_soft_reset
        |=> o_adc_sample == (($past(o_adc_sample) == 14'h1555) ? 14'h2aaa : 14'h1555)) else $error("checker wrong");
    a_ramp_step: assert property (mode_q == 4'hf && age_q >= 2'd2 && !mode_wr && !o_soft_reset
        |=> o_adc_sample == $past(o_adc_sample) + 14'h0001) else $error("ramp step wrong");
    a_disc_code: assert property (o_adc_disconnect == (mode_q != 4'h0)) else $error("disconnect wrong");
    a_soft_cause: assert property (i_wr && i_addr == 16'h0000 && i_wdata == 8'h81 && !o_soft_reset
        |=> o_soft_reset) else $error("soft reset missing");
    a_soft_pulse: assert property (o_soft_reset |=> !o_soft_reset) else $error("soft reset long");
    a_soft_clear: assert property (o_soft_reset |=> o_if_point == 2'b00 && o_dll_test_sel == 3'h0
        && o_link_ctrl == 8'h00 && !o_tl_test_en && !o_adc_disconnect) else $error("soft reset kept state");
    a_point_field: assert property (i_wr && i_addr == 16'h0573 && !o_soft_reset
        |=> o_if_point == $past(wd_point)) else $error("injection point wrong");
    a_width_map: assert property (o_if_width == ((o_if_point == 2'b01) ? 5'd10
        : (o_if_point == 2'b10) ? 5'd8 : 5'd16)) else $error("width wrong");
    c_chk_run: cover property (mode_q == 4'h4 && age_q == 2'd3);
    c_soft: cover property (o_soft_reset);
    c_octet: cover property (o_if_point == 2'b10);
endmodule // atpg_properties
bind atpg_top atpg_properties atpg_properties_i (.*);

// >>> tb/atpg_rx_model.sv
`timescale 1ns/1ps
module atpg_rx_model (
    input wire i_clk,
    input wire i_nrst,
    input wire i_valid,
    input wire [15:0] i_word,
    input wire [4:0] i_width,
    output reg [15:0] o_count,
    output reg o_width_err
);
    reg [4:0] w_q;
    reg [4:0] w_qq;
    // Width is judged only once it has held two cycles, since the word lags a point change.
    always @(posedge i_clk) begin
        w_q <= i_width;
        w_qq <= w_q;
        if (!i_nrst) begin
            o_count <= 16'h0000;
            o_width_err <= 1'b0;
        end else if (i_valid) begin
            o_count <= o_count + 16'h0001;
            if (w_q == i_width && w_qq == i_width && (i_word >> i_width) != 16'h0000) begin
                o_width_err <= 1'b1;
            end
        end
    end
endmodule // atpg_rx_model

// >>> tb/tb_atpg_top.sv
`timescale 1ns/1ps
module tb_atpg_top;
    reg clk, nrst, wr, rd;
    reg [15:0] addr, ra, p0, p1, q0, q1, m;
    reg [7:0] wdata, c;
    reg [13:0] adc_in, s;
    reg [4:0] wd;
    reg [1:0] pt;
    integer failures, check_count, j;
    wire [7:0] rdata, link_ctrl;
    wire [13:0] adc_s;
    wire [15:0] if_word, rx_count;
    wire [4:0] if_width;
    wire [1:0] if_point;
    wire [2:0] dll_sel;
    wire disc, if_valid, tl_en, soft_rst, rx_err;
    localparam [15:0] W1 = 16'hc3a5, W2 = 16'h5a3c, W3 = 16'h0ff4, W4 = 16'hf00b;
    atpg_top atpg_top_i (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_adc_sample(adc_in), .o_adc_sample(adc_s), .o_adc_disconnect(disc),
        .o_if_word(if_word), .o_if_width(if_width), .o_if_point(if_point), .o_if_valid(if_valid),
        .o_tl_test_en(tl_en), .o_dll_test_sel(dll_sel), .o_link_ctrl(link_ctrl), .o_soft_reset(soft_rst));
    atpg_rx_model atpg_rx_model_i (.i_clk(clk), .i_nrst(nrst), .i_valid(if_valid), .i_word(if_word),
        .i_width(if_width), .o_count(rx_count), .o_width_err(rx_err));
    always #5 clk = ~clk;
    always @(posedge clk) adc_in <= adc_in + 14'h0001;
    //////////////////////////////
    task check(input [8*12-1:0] what, input [15:0] exp, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr_reg(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_check(input [15:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            check("rdata", {8'h00, e}, {8'h00, rdata});
        end
    endtask
    task pat5(input is_if, input [15:0] e0, e1, e2, e3, e4);
        reg [79:0] e;
        integer k;
        begin
            e = {e0, e1, e2, e3, e4};
            for (k = 0; k < 5; k = k + 1) begin
                @(posedge clk);
                #1;
                check(is_if ? "if_word" : "adc_sample", e[79 - 16 * k -: 16], is_if ? if_word : {2'b00, adc_s});
            end
        end
    endtask
    task grab(input is_if, output [15:0] a, output [15:0] b);
        begin
            repeat (2) @(posedge clk);
            #1;
            a = is_if ? if_word : {2'b00, adc_s};
            @(posedge clk);
            #1;
            b = is_if ? if_word : {2'b00, adc_s};
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    //////////////////////////////
    initial begin
        #900000;
        failures = failures + 1;
        tally_and_finish;
    end
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {wr, rd, addr, wdata, adc_in} = 0;
        failures = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        wr_reg(16'h0123, 8'h5a);
        rd_check(16'h0123, 8'h00);
        rd_check(16'h0550, 8'h00);
        rd_check(16'h0573, 8'h00);
        #1;
        check("raw_path", {2'b00, adc_in - 14'h0001}, {2'b00, adc_s});
        for (c = 8'h01; c <= 8'h03; c = c + 8'h01) begin
            wr_reg(16'h0550, c);
            m = (c == 8'h01) ? 16'h0000 : (c == 8'h02) ? 16'h1fff : 16'h2000;
            pat5(0, m, m, m, m, m);
            check("disconnect", 16'h0001, {15'h0, disc});
        end
        wr_reg(16'h0550, 8'h04);
        pat5(0, 16'h1555, 16'h2aaa, 16'h1555, 16'h2aaa, 16'h1555);
        wr_reg(16'h0550, 8'h07);
        pat5(0, 16'h0000, 16'h3fff, 16'h0000, 16'h3fff, 16'h0000);
        wr_reg(16'h0550, 8'h0f);
        pat5(0, 16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004);
        for (j = 0; j < 7; j = j + 1) begin
            ra = (j < 2) ? 16'h0550 : 16'h0573;
            c = (j < 2) ? 8'h05 + j[7:0] : 8'h01 + j[7:0];
            wr_reg(ra, c);
            grab(j >= 2, p0, p1);
            wr_reg(ra, c);
            grab(j >= 2, q0, q1);
            check("pn_restart", p0, q0);
            check("pn_moves", 16'h0001, {15'h0, p0 !== p1});
            if (j < 2) begin
                wr_reg(ra, c | (8'h10 << j));
                grab(0, q0, q1);
                check("pn_hold", q0, q1);
            end
        end
        for (j = 0; j < 8; j = j + 1) wr_reg(16'h0551 + j[15:0], {W1, W2, W3, W4} >> (8 * (6 - (j & 6) + (j & 1))));
        wr_reg(16'h0550, 8'h08);
        pat5(0, W1 >> 2, W2 >> 2, W3 >> 2, W4 >> 2, W1 >> 2);
        wr_reg(16'h0550, 8'h88);
        pat5(0, W1 >> 2, W2 >> 2, W3 >> 2, W4 >> 2, 16'h0000);
        for (pt = 2'b00; pt != 2'b11; pt = pt + 2'b01) begin
            wd = (pt == 2'b01) ? 5'd10 : (pt == 2'b10) ? 5'd8 : 5'd16;
            m = 16'hffff >> (5'd16 - wd);
            wr_reg(16'h0573, {2'b00, pt, 4'h1});
            pat5(1, 16'h5555 & m, 16'haaaa & m, 16'h5555 & m, 16'haaaa & m, 16'h5555 & m);
            check("if_point", {14'h0, pt}, {14'h0, if_point});
            check("if_width", {11'h0, wd}, {11'h0, if_width});
            check("if_valid", 16'h0001, {15'h0, if_valid});
            wr_reg(16'h0573, {2'b00, pt, 4'h2});
            pat5(1, 16'h0000, m, 16'h0000, m, 16'h0000);
            wr_reg(16'h0573, {2'b00, pt, 4'h8});
            pat5(1, 16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004);
            wr_reg(16'h0573, {2'b00, pt, 4'he});
            pat5(1, W1 >> (16 - wd), W2 >> (16 - wd), W3 >> (16 - wd), W4 >> (16 - wd), W1 >> (16 - wd));
            wr_reg(16'h0573, {2'b00, pt, 4'hf});
            pat5(1, W1 >> (16 - wd), W2 >> (16 - wd), W3 >> (16 - wd), W4 >> (16 - wd), 16'h0000);
        end
        wr_reg(16'h0573, 8'h28);
        repeat (257) @(posedge clk);
        #1;
        check("if_wrap", 16'h0000, if_word);
        check("rx_width", 16'h0000, {15'h0, rx_err});
        wr_reg(16'h0000, 8'h55);
        #1;
        check("soft_reset", 16'h0000, {15'h0, soft_rst});
        wr_reg(16'h0000, 8'h81);
        #1;
        check("soft_reset", 16'h0001, {15'h0, soft_rst});
        @(posedge clk);
        #1;
        check("soft_reset", 16'h0000, {15'h0, soft_rst});
        rd_check(16'h0573, 8'h00);
        rd_check(16'h0000, 8'h00);
        wr_reg(16'h0572, 8'hc0);
        wr_reg(16'h0574, 8'h05);
        rd_check(16'h0574, 8'h05);
        check("dll_sel", 16'h0005, {13'h0, dll_sel});
        check("link_ctrl", 16'h00c0, {8'h00, link_ctrl});
        wr_reg(16'h0571, 8'h20);
        grab(0, p0, p1);
        s = p0[13:0];
        #1;
        check("tl_word", {s, 2'b00}, if_word);
        check("tl_en", 16'h0001, {15'h0, tl_en});
        check("rx_seen", 16'h0001, {15'h0, rx_count != 16'h0000});
        tally_and_finish;
    end
endmodule // tb_atpg_top
